/* File: shared/lptc_defines.svh */
`ifndef LPTC_DEFINES_SVH
`define LPTC_DEFINES_SVH

// ************************************************************
// Register offsets, word addressed on the plain register port.
// ************************************************************
`define LPTC_OFF_CTRL 4'h0
`define LPTC_OFF_DIV 4'h1
`define LPTC_OFF_CMP 4'h2
`define LPTC_OFF_CNT 4'h3
`define LPTC_OFF_STAT 4'h4
`define LPTC_OFF_MASK 4'h5

// ************************************************************
// Control register field positions.
// ************************************************************
`define LPTC_CTRL_EN 0
`define LPTC_CTRL_MODE 1
`define LPTC_CTRL_FREE 2
`define LPTC_CTRL_POL 3
`define LPTC_CTRL_SEL_LO 4
`define LPTC_CTRL_DMA 6

// ************************************************************
// Divider register field positions.
// ************************************************************
`define LPTC_DIV_VAL_LO 0
`define LPTC_DIV_SRC_LO 4
`define LPTC_DIV_BYP 6

// ************************************************************
// Reset values.
// ************************************************************
`define LPTC_CTRL_RST 7'h00
`define LPTC_DIV_RST 7'h41
`define LPTC_CMP_RST 16'h0000

`endif

/* File: shared/lptc_pkg.sv */
package lptc_pkg;

    typedef enum logic {
        LPTC_MODE_TIME,
        LPTC_MODE_PULSE
    } lptc_mode_t;

    typedef enum logic [1:0] {
        LPTC_CNT_IDLE,
        LPTC_CNT_RUN
    } lptc_state_t;

    // Counting configuration as one bundle.
    typedef struct packed {
        logic enable;
        lptc_mode_t count_mode_select;
        logic free_run_enable;
        logic pulse_input_polarity;
        logic [1:0] pulse_input_select;
        logic dma_enable;
        logic divider_bypass;
        logic [1:0] divider_clock_source;
        logic [3:0] divider_value;
    } lptc_cfg_t;

endpackage

/* File: logic/lptc_tick_gen.sv */
`timescale 1ns/1ps
// Prescaler and glitch filter that turns the chosen source into count ticks.
module lptc_tick_gen
    import lptc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Configuration.
    input wire lptc_cfg_t cfg,
    input wire logic run,
    // Sources.
    input wire logic [3:0] clk_src,
    input wire logic [3:0] pulse_in,
    // Result.
    output logic tick
);

    logic src_prev;
    logic filt;
    logic filt_prev;
    logic [15:0] div_cnt;
    logic [15:0] flt_cnt;
    logic raw;
    logic src_rise;
    logic filt_rise;
    logic div_tick;
    logic sclk_prev;
    logic sclk_rise;

    // Returns two to the power n, minus one, as a 16-bit terminal count.
    function automatic logic [15:0] pow2_m1(input logic [4:0] n);
        logic [16:0] p;
        p = 17'h00001 << n;
        return 16'(p - 17'h00001);
    endfunction

    // Pick the raw level; pulse inputs only matter in pulse mode.
    always_comb begin
        if (cfg.count_mode_select == LPTC_MODE_PULSE) begin
            raw = pulse_in[cfg.pulse_input_select] ^ cfg.pulse_input_polarity; // R6 R7
        end else begin
            raw = clk_src[cfg.divider_clock_source]; // R3 R5
        end
    end

    // Edge history of the raw source.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= raw;
        end
    end

    assign src_rise = raw & ~src_prev;

    // Prescaler counts source rising edges; terminal count 2^(n+1)-1.
    always_ff @(posedge CLK) begin
        if (SYS_RST || !run) begin
            div_cnt <= 16'h0000;
        end else if (src_rise) begin
            if (div_cnt == pow2_m1(5'(cfg.divider_value) + 5'h01)) begin // R1 R2
                div_cnt <= 16'h0000;
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end

    assign div_tick = src_rise && (div_cnt == pow2_m1(5'(cfg.divider_value) + 5'h01));

    // Edge history of the selected source clock, which paces the filter in pulse mode.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= clk_src[cfg.divider_clock_source];
        end
    end

    assign sclk_rise = clk_src[cfg.divider_clock_source] & ~sclk_prev; // R3

    // Glitch filter: the new level must stand over 2^n source clock edges before it passes.
    // Setting zero is not supported and is treated as setting one.
    always_ff @(posedge CLK) begin
        if (SYS_RST || !run) begin
            flt_cnt <= 16'h0000;
            filt <= 1'b0;
        end else if (raw == filt) begin
            flt_cnt <= 16'h0000;
        end else if (sclk_rise) begin
            if (flt_cnt == pow2_m1((cfg.divider_value == 4'h0) ? 5'h01 :
                                   5'(cfg.divider_value))) begin // R1 R2
                flt_cnt <= 16'h0000;
                filt <= raw;
            end else begin
                flt_cnt <= flt_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            filt_prev <= 1'b0;
        end else begin
            filt_prev <= filt;
        end
    end

    assign filt_rise = filt & ~filt_prev;

    // Bypass counts raw edges; otherwise prescaler or filter output.
    always_comb begin
        if (cfg.divider_bypass) begin
            tick = src_rise; // R4
        end else if (cfg.count_mode_select == LPTC_MODE_PULSE) begin
            tick = filt_rise; // R4
        end else begin
            tick = div_tick; // R4
        end
    end

endmodule

/* File: logic/lptc_timer.sv */
`timescale 1ns/1ps
`include "lptc_defines.svh"
// Operation
// (R1) Prescale n of 1..15 divides by 2^(n+1), filters 2^n clocks.
// (R2) Prescale zero divides by two; the filter does not support it.
// (R3) A 2-bit field picks one of four divider clock sources.
// (R4) Bypass counts the raw source; otherwise the divider or filter output.
// (R5) Mode selects time counting or pulse counting.
// (R6) Pulse input select picks one of four pins, in pulse mode only.
// (R7) Polarity inverts the pulse input, in pulse mode only.
// (R8) Free run resets on overflow; otherwise resets when the flag sets.
// (R9) One compare flag, readable and clearable by software.
// (R10) Interrupt enable gates the compare flag onto the interrupt.
// (R11) A separate enable lets the compare event request DMA.
// (R12) Counter at compare value then incrementing pulses trigger and sets flag.
// (R13) Disabling stops counting and clears the counter.
// (R14) Writing one clears the flag; a same-cycle set wins.
module lptc_timer
    import lptc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Register port.
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Count sources.
    input wire logic [3:0] CLK_SRC,
    input wire logic [3:0] PULSE_IN,
    // Events.
    output logic IRQ,
    output logic DMA_REQ,
    output logic TRIGGER
);

    // ************************************************************
    // Registers.
    // ************************************************************
    logic [6:0] ctrl;
    logic [6:0] divr;
    logic [15:0] compare;
    logic [15:0] count;
    logic compare_match_flag;
    logic compare_irq_enable;
    lptc_cfg_t cfg;
    lptc_state_t state;
    logic tick;
    logic hit;
    logic clr_flag;
    logic [15:0] next_count;

    // Decodes a write to a given word offset.
    function automatic logic wr_at(input logic [3:0] a, input logic [3:0] off,
                                   input logic w);
        return w && (a == off);
    endfunction

    assign cfg.enable = ctrl[`LPTC_CTRL_EN];
    assign cfg.count_mode_select = lptc_mode_t'(ctrl[`LPTC_CTRL_MODE]);
    assign cfg.free_run_enable = ctrl[`LPTC_CTRL_FREE];
    assign cfg.pulse_input_polarity = ctrl[`LPTC_CTRL_POL];
    assign cfg.pulse_input_select = ctrl[`LPTC_CTRL_SEL_LO +: 2];
    assign cfg.dma_enable = ctrl[`LPTC_CTRL_DMA];
    assign cfg.divider_value = divr[`LPTC_DIV_VAL_LO +: 4];
    assign cfg.divider_clock_source = divr[`LPTC_DIV_SRC_LO +: 2];
    assign cfg.divider_bypass = divr[`LPTC_DIV_BYP];

    // Configuration writes; changing settings while running takes effect at once.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl <= `LPTC_CTRL_RST;
            divr <= `LPTC_DIV_RST;
            compare <= `LPTC_CMP_RST;
            compare_irq_enable <= 1'b0;
        end else begin
            if (wr_at(ADDR, `LPTC_OFF_CTRL, WR)) begin
                ctrl <= WDATA[6:0];
            end
            if (wr_at(ADDR, `LPTC_OFF_DIV, WR)) begin
                divr <= WDATA[6:0];
            end
            if (wr_at(ADDR, `LPTC_OFF_CMP, WR)) begin
                compare <= WDATA;
            end
            if (wr_at(ADDR, `LPTC_OFF_MASK, WR)) begin
                compare_irq_enable <= WDATA[0];
            end
        end
    end

    // ************************************************************
    // Counting.
    // ************************************************************
    lptc_tick_gen u_tick (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .cfg(cfg),
        .run(state == LPTC_CNT_RUN),
        .clk_src(CLK_SRC),
        .pulse_in(PULSE_IN),
        .tick(tick)
    );

    // Run state follows the enable bit.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state <= LPTC_CNT_IDLE;
        end else begin
            case (state)
                LPTC_CNT_IDLE: begin
                    if (cfg.enable) begin
                        state <= LPTC_CNT_RUN;
                    end
                end
                LPTC_CNT_RUN: begin
                    if (!cfg.enable) begin
                        state <= LPTC_CNT_IDLE;
                    end
                end
                default: begin
                    state <= LPTC_CNT_IDLE;
                end
            endcase
        end
    end

    // The match is taken when the counter leaves the compare value.
    assign hit = (state == LPTC_CNT_RUN) && tick && (count == compare); // R12

    // Without free run the counter restarts on the hit; with it, wraps at overflow.
    always_comb begin
        next_count = count;
        if (hit && !cfg.free_run_enable) begin
            next_count = 16'h0000; // R8
        end else if (tick) begin
            next_count = count + 16'h0001; // R8
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST || state != LPTC_CNT_RUN || !cfg.enable) begin
            count <= 16'h0000; // R13
        end else begin
            count <= next_count;
        end
    end

    // ************************************************************
    // Flag, interrupt and DMA.
    // ************************************************************
    assign clr_flag = wr_at(ADDR, `LPTC_OFF_STAT, WR) && WDATA[0];

    // Set has priority so an event in the clearing cycle is kept.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            compare_match_flag <= 1'b0;
        end else if (hit) begin
            compare_match_flag <= 1'b1; // R9 R14
        end else if (clr_flag) begin
            compare_match_flag <= 1'b0; // R14
        end
    end

    // Trigger and DMA request are one-cycle pulses registered from the hit.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            TRIGGER <= 1'b0;
            DMA_REQ <= 1'b0;
        end else begin
            TRIGGER <= hit; // R12
            DMA_REQ <= hit && cfg.dma_enable; // R11
        end
    end

    assign IRQ = compare_match_flag && compare_irq_enable; // R10

    // Read data appear in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            case (ADDR)
                `LPTC_OFF_CTRL: RDATA <= {9'h000, ctrl};
                `LPTC_OFF_DIV: RDATA <= {9'h000, divr};
                `LPTC_OFF_CMP: RDATA <= compare;
                `LPTC_OFF_CNT: RDATA <= count;
                `LPTC_OFF_STAT: RDATA <= {15'h0000, compare_match_flag}; // R9
                `LPTC_OFF_MASK: RDATA <= {15'h0000, compare_irq_enable};
                default: RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

endmodule

/* File: tb/lptc_src_model.sv */
`timescale 1ns/1ps
// Free-running source clocks and synchronous pulse pins at the timer's far side.
module lptc_src_model (
    // Clock and pin levels asked for by the bench.
    input wire logic CLK,
    input wire logic [3:0] pin_lvl,
    // Lines seen by the timer.
    output logic [3:0] CLK_SRC = 4'h0,
    output logic [3:0] PULSE_IN = 4'h0
);
    logic [3:0] cnt [4] = '{4'h0, 4'h0, 4'h0, 4'h0};

    // Source i has a half period of i+2 cycles, so each stays below half the system rate.
    always @(posedge CLK) begin
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= (cnt[i] == 4'(i + 1)) ? 4'h0 : cnt[i] + 4'h1;
            if (cnt[i] == 4'(i + 1)) CLK_SRC[i] <= ~CLK_SRC[i];
        end
        PULSE_IN <= pin_lvl;
    end
endmodule

/* File: tb/lptc_timer_chk.sv */
`timescale 1ns/1ps
// Checker on the timer's ports.
module lptc_timer_chk (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Register port.
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // Events.
    input wire logic IRQ,
    input wire logic DMA_REQ,
    input wire logic TRIGGER
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // ****
    // Assertions
    // ****
    rd_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not idle");
    trig_pulse_a: assert property (TRIGGER |=> !TRIGGER)
        else $error("trigger longer than one cycle");
    dma_with_trig_a: assert property (DMA_REQ |-> TRIGGER)
        else $error("dma request without compare event");
    irq_rise_a: assert property ($rose(IRQ) |-> TRIGGER || $past(WR && ADDR == 4'h5))
        else $error("interrupt rose without cause");
    irq_fall_a: assert property ($fell(IRQ) |-> $past(WR) && $past(ADDR) inside {4'h4, 4'h5})
        else $error("interrupt fell without clear");
    cmp_back_a: assert property (WR && ADDR == 4'h2 ##2 RD && ADDR == 4'h2
        |=> RDATA == $past(WDATA, 3))
        else $error("compare value readback wrong");
    stop_clear_a: assert property (WR && ADDR == 4'h0 && !WDATA[0] ##2 RD && ADDR == 4'h3
        |=> RDATA == 16'h0000)
        else $error("counter not cleared on stop");
    flag_bits_a: assert property (RD && ADDR == 4'h4 |=> RDATA[15:1] == 15'h0000)
        else $error("status reserved bits set");
    unmapped_rd_a: assert property (RD && ADDR > 4'h5 |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind lptc_timer lptc_timer_chk u_lptc_timer_chk (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .IRQ, .DMA_REQ, .TRIGGER);

/* File: tb/lptc_timer_tb.sv */
`timescale 1ns/1ps
module lptc_timer_tb;
    logic CLK = 0, SYS_RST = 1, WR = 0, RD = 0, rd_d = 0;
    logic [3:0] ADDR = 0, pin_lvl = 0, CLK_SRC, PULSE_IN;
    logic [15:0] WDATA = 0, RDATA;
    logic IRQ, DMA_REQ, TRIGGER;
    logic [15:0] rst_v [7] = '{16'h0, 16'h41, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [31:0] expq [$];
    int error_cnt = 0, checked = 0, n, k, np, f;

    lptc_timer u_lptc_timer (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .CLK_SRC,
        .PULSE_IN, .IRQ, .DMA_REQ, .TRIGGER);
    lptc_src_model u_lptc_src_model (.CLK, .pin_lvl, .CLK_SRC, .PULSE_IN);

    // ****
    // Tasks
    // ****
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask
    task finish_test;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Each access leaves one idle cycle, so no strobe is assigned twice in a time step.
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1;
        @(posedge CLK);
        WR <= 0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        expq.push_back(e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1;
        @(posedge CLK);
        RD <= 0;
    endtask
    // Counts cycles up to the next compare event, with a bound against a hang.
    task trig(output int c);
        c = 0;
        do begin
            @(negedge CLK);
            c++;
        end while (TRIGGER !== 1'b1 && c < 3000);
        if (c >= 3000) error_cnt++;
    endtask
    // Drives pin b high for len cycles, then low long enough for the filter to settle.
    task pulse(input int b, input int len);
        @(posedge CLK);
        pin_lvl <= 4'(1 << b);
        repeat (len) @(posedge CLK);
        pin_lvl <= 4'h0;
        repeat (48) @(posedge CLK);
    endtask

    // ****
    // Clock, monitor, watchdog
    // ****
    initial forever #12.5 CLK = ~CLK;
    // Read data stand only in the cycle after the strobe, so compare mid-cycle there.
    always @(posedge CLK) rd_d <= RD;
    always @(negedge CLK) if (rd_d) chk("rdata", RDATA, expq.pop_front());
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        finish_test;
    end

    // ****
    // Main sequence
    // ****
    initial begin
        void'($urandom(29));
        repeat (6) @(posedge CLK);
        SYS_RST <= 0;
        foreach (rst_v[i]) rd(4'(i), rst_v[i]);
        // Bypass on each source; interval is (compare+1) source periods.
        for (int s = 0; s < 4; s++) begin
            wr(4'h1, 16'h40 | 16'(s << 4));
            wr(4'h2, 16'h3);
            wr(4'h5, 16'(s & 1));
            wr(4'h0, 16'h1 | 16'((s >> 1) << 6));
            trig(n);
            trig(n);
            chk("interval", n, 8 * (s + 2));
            chk("irq", IRQ, s & 1);
            chk("dma", DMA_REQ, s >> 1);
            rd(4'h3, 16'h0);
            rd(4'h4, 16'h1);
            wr(4'h4, 16'h1);
            rd(4'h4, 16'h0);
            wr(4'h0, 16'h0);
            rd(4'h3, 16'h0);
        end
        // Free run keeps counting past the compare value.
        wr(4'h1, 16'h40);
        wr(4'h0, 16'h5);
        trig(n);
        rd(4'h3, 16'h4);
        wr(4'h0, 16'h0);
        // Prescaler on source 0 divides by two to the power value plus one.
        for (int v = 0; v < 3; v++) begin
            wr(4'h1, 16'(v));
            wr(4'h2, 16'h1);
            rd(4'h2, 16'h1);
            wr(4'h0, 16'h1);
            trig(n);
            trig(n);
            chk("prescale", n, 16 << v);
            wr(4'h0, 16'h0);
        end
        // Pulse mode ends on an active level so a wrong polarity gives one edge fewer.
        wr(4'h1, 16'h40);
        wr(4'h2, 16'hffff);
        for (int p = 0; p < 2; p++) begin
            k = $urandom % 4;
            np = $urandom % 5 + 1;
            @(posedge CLK) pin_lvl <= p ? 4'(1 << k) : ~4'(1 << k);
            wr(4'h0, 16'h3 | 16'(p << 3) | 16'(k << 4));
            repeat (2 * np - 1) begin
                @(posedge CLK) pin_lvl <= pin_lvl ^ 4'(1 << k);
                repeat (3) @(posedge CLK);
            end
            rd(4'h3, 16'(np));
            wr(4'h0, 16'h0);
        end
        // Glitch filter on source 0: a pulse shorter than 2^n source clocks is dropped.
        for (int v = 0; v < 3; v++) begin
            k = $urandom % 4;
            np = $urandom % 3 + 1;
            // Filter length in source clocks; setting zero behaves as setting one.
            f = (v == 0) ? 2 : 1 << v;
            wr(4'h1, 16'(v));
            wr(4'h0, 16'h3 | 16'(k << 4));
            repeat (np) begin
                pulse(k, 4 * (f - 1));
                pulse(k, 4 * f + 8);
            end
            rd(4'h3, 16'(np));
            wr(4'h0, 16'h0);
        end
        repeat (4) @(posedge CLK);
        finish_test;
    end
endmodule
